// >>> design/spi_command_port_busy.sv
`timescale 1ns/1ps
`include "spi_cmd_defines.svh"
module spi_command_port_busy
#(
	parameter int unsigned DGRAM_BYTES = `DGRAM_BYTES_DEF,
	parameter int unsigned PROC_MIN_CYC = `PROC_MIN_US * `CLK_MHZ,
	parameter int unsigned PROC_MAX_CYC = `PROC_MAX_US * `CLK_MHZ
)
(
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic RST_N,
	// pin function selection
	input wire logic SERIAL_SEL,
	input wire logic GPIO_THREE_OUT,
	// serial link pins
	input wire logic PORT_SELECT_N,
	input wire logic SPI_SCK,
	input wire logic SPI_MOSI,
	output logic SPI_MISO,
	output logic SPI_MISO_OE,
	output logic GENERAL_PIN_THREE,
	// command bytes towards the interpreter
	output spi_cmd_pkg::cmd_byte_t CMD_DATA,
	output logic CMD_LAST,
	output logic CMD_VALID,
	input wire logic CMD_READY,
	// result from the interpreter
	input wire logic [DGRAM_BYTES*8-1:0] RESULT_DATA,
	input wire logic RESULT_VALID
);
	import spi_cmd_pkg::*;
	localparam int unsigned RW = DGRAM_BYTES * 8;
	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [2:0] pin_raw;
	logic [2:0] pin_meta_q;
	logic [2:0] pin_sync_q;
	logic [2:0] rst_lvl;
	assign pin_raw = {PORT_SELECT_N, SPI_SCK, SPI_MOSI};
	assign rst_lvl = `SYNC_RST;
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_sync
			always_ff @(posedge SYS_CLK)
			begin
				if (!RST_N)
				begin
					pin_meta_q[gi] <= rst_lvl[gi];
					pin_sync_q[gi] <= rst_lvl[gi];
				end
				else
				begin
					pin_meta_q[gi] <= pin_raw[gi];
					pin_sync_q[gi] <= pin_meta_q[gi];
				end
			end
		end
	endgenerate
	logic sel_n, sck, mosi;
	logic sck_prev_q, sel_prev_q;
	logic sck_rise, sck_fall, dg_start, dg_end;
	assign sel_n = pin_sync_q[`SYNC_SEL];
	assign sck = pin_sync_q[`SYNC_SCK];
	assign mosi = pin_sync_q[`SYNC_MOSI];
	assign sck_rise = SERIAL_SEL && !sel_n && sck && !sck_prev_q;
	assign sck_fall = SERIAL_SEL && !sel_n && !sck && sck_prev_q;
	assign dg_start = SERIAL_SEL && !sel_n && sel_prev_q;
	assign dg_end = sel_n && !sel_prev_q;
	always_ff @(posedge SYS_CLK)
	begin
		if (!RST_N)
		begin
			sck_prev_q <= 1'b1;
			sel_prev_q <= 1'b1;
		end
		else
		begin
			sck_prev_q <= sck;
			sel_prev_q <= sel_n;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// command buffer
	cmd_fifo_if #(.W(`CMD_W)) cf();
	cmd_fifo #(.W(`CMD_W), .DEPTH(`FIFO_DEPTH)) u_fifo
	(
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.f(cf.store)
	);
	////////////////////////////////////////////////////////////////////////////////
	// link state, shifters and busy
	link_state_t state_q, state_d;
	logic [7:0] rx_q, rx_d;
	logic [2:0] bit_q, bit_d;
	logic [7:0] byte_q, byte_d;
	logic [RW-1:0] tx_q, tx_d;
	logic [RW-1:0] res_q, res_d;
	logic res_ok_q, res_ok_d;
	logic miso_q, miso_d;
	logic oe_q, oe_d;
	logic busy_q, busy_d;
	logic pin3_q, pin3_d;
	logic [`TIMER_W-1:0] timer_q, timer_d;
	logic push_q, push_d;
	cmd_word_t pword_q, pword_d;
	assign cf.in_valid = push_q;
	assign cf.in_data = pword_q;
	always_comb
	begin
		state_d = state_q;
		rx_d = rx_q;
		bit_d = bit_q;
		byte_d = byte_q;
		tx_d = tx_q;
		res_d = res_q;
		res_ok_d = res_ok_q;
		miso_d = miso_q;
		busy_d = busy_q;
		timer_d = timer_q;
		push_d = push_q;
		pword_d = pword_q;
		// a waiting byte leaves once the buffer takes it
		if (push_q && cf.in_ready)
			push_d = 1'b0;
		if (RESULT_VALID)
		begin
			res_d = RESULT_DATA;
			res_ok_d = 1'b1;
		end
		oe_d = SERIAL_SEL && !sel_n;
		case (state_q)
			ST_IDLE:
			begin
				if (dg_start)
				begin
					busy_d = 1'b1;
					state_d = ST_RECV;
					bit_d = '0;
					byte_d = '0;
					res_ok_d = 1'b0;
				end
			end
			ST_RECV:
			begin
				if (sck_rise)
				begin
					rx_d = {rx_q[6:0], mosi};
					bit_d = bit_q + 1'b1;
					if (bit_q == 3'h7 && byte_q < 8'(DGRAM_BYTES))
					begin
						byte_d = byte_q + 1'b1;
						// a stalled byte is replaced by the newer one
						push_d = 1'b1;
						pword_d.data = {rx_q[6:0], mosi};
						pword_d.last = (byte_q == 8'(DGRAM_BYTES - 1));
					end
				end
				if (sck_fall)
				begin
					// result leaves in the following datagram
					miso_d = tx_q[RW-1];
					tx_d = {tx_q[RW-2:0], 1'b0};
				end
				if (dg_end)
				begin
					timer_d = '0;
					if (byte_q == 8'(DGRAM_BYTES))
						state_d = ST_PROC;
					else
					begin
						// short frame carries no command, nothing to wait for
						state_d = ST_IDLE;
						busy_d = 1'b0;
					end
				end
			end
			ST_PROC:
			begin
				timer_d = timer_q + 1'b1;
				if (dg_start)
				begin
					// early datagram discards the result and clears the reply shifter
					state_d = ST_RECV;
					bit_d = '0;
					byte_d = '0;
					res_ok_d = 1'b0;
					tx_d = '0;
				end
				// release busy within the processing window
				else if ((res_ok_q && timer_q >= `TIMER_W'(PROC_MIN_CYC - 1))
					|| timer_q >= `TIMER_W'(PROC_MAX_CYC - 1))
				begin
					state_d = ST_IDLE;
					busy_d = 1'b0;
					// reply only what the command produced
					tx_d = res_ok_q ? res_q : '0;
				end
			end
			default:
			begin
				state_d = ST_IDLE;
				busy_d = 1'b0;
			end
		endcase
		if (sel_n)
			miso_d = 1'b0;
		// pin three carries busy in serial mode
		pin3_d = SERIAL_SEL ? busy_d : GPIO_THREE_OUT;
	end
	always_ff @(posedge SYS_CLK)
	begin
		if (!RST_N)
		begin
			state_q <= ST_IDLE;
			rx_q <= '0;
			bit_q <= '0;
			byte_q <= '0;
			tx_q <= '0;
			res_q <= '0;
			res_ok_q <= 1'b0;
			miso_q <= 1'b0;
			oe_q <= 1'b0;
			busy_q <= 1'b0;
			pin3_q <= 1'b0;
			timer_q <= '0;
			push_q <= 1'b0;
			pword_q <= '0;
		end
		else
		begin
			state_q <= state_d;
			rx_q <= rx_d;
			bit_q <= bit_d;
			byte_q <= byte_d;
			tx_q <= tx_d;
			res_q <= res_d;
			res_ok_q <= res_ok_d;
			miso_q <= miso_d;
			oe_q <= oe_d;
			busy_q <= busy_d;
			pin3_q <= pin3_d;
			timer_q <= timer_d;
			push_q <= push_d;
			pword_q <= pword_d;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// registered command output stage
	logic cmd_valid_q, cmd_valid_d;
	cmd_word_t cmd_q, cmd_d;
	// bytes reach the interpreter as on the other port
	assign cf.out_ready = !cmd_valid_q || CMD_READY;
	always_comb
	begin
		cmd_valid_d = cf.out_ready ? cf.out_valid : cmd_valid_q;
		cmd_d = (cf.out_ready && cf.out_valid) ? cmd_word_t'(cf.out_data) : cmd_q;
	end
	always_ff @(posedge SYS_CLK)
	begin
		if (!RST_N)
		begin
			cmd_valid_q <= 1'b0;
			cmd_q <= '0;
		end
		else
		begin
			cmd_valid_q <= cmd_valid_d;
			cmd_q <= cmd_d;
		end
	end
	assign SPI_MISO = miso_q;
	assign SPI_MISO_OE = oe_q;
	assign GENERAL_PIN_THREE = pin3_q;
	assign CMD_DATA = cmd_q.data;
	assign CMD_LAST = cmd_q.last;
	assign CMD_VALID = cmd_valid_q;
endmodule : spi_command_port_busy

// >>> design/spi_cmd_defines.svh
`ifndef SPI_CMD_DEFINES_SVH
`define SPI_CMD_DEFINES_SVH

// system clock rate
`define CLK_MHZ 100
// command processing window, in microseconds
`define PROC_MIN_US 100
`define PROC_MAX_US 5000
`define TIMER_W 20
// datagram length in bytes, default
`define DGRAM_BYTES_DEF 9
// command stream buffer
`define FIFO_DEPTH 4
`define CMD_W 9
// synchroniser bit positions and reset levels (select idle high, clock idle high)
`define SYNC_SEL 2
`define SYNC_SCK 1
`define SYNC_MOSI 0
`define SYNC_RST 3'b110

`endif

// >>> design/spi_cmd_pkg.sv
package spi_cmd_pkg;

	typedef enum logic [1:0] {ST_IDLE, ST_RECV, ST_PROC} link_state_t;

	typedef logic [7:0] cmd_byte_t;

	typedef struct packed
	{
		logic last;
		cmd_byte_t data;
	} cmd_word_t;

endpackage : spi_cmd_pkg

// >>> design/cmd_fifo_if.sv
`timescale 1ns/1ps
interface cmd_fifo_if #(parameter int unsigned W = 9);
	logic in_valid;
	logic in_ready;
	logic [W-1:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [W-1:0] out_data;

	modport store
	(
		input in_valid,
		input in_data,
		input out_ready,
		output in_ready,
		output out_valid,
		output out_data
	);

	modport user
	(
		output in_valid,
		output in_data,
		output out_ready,
		input in_ready,
		input out_valid,
		input out_data
	);
endinterface : cmd_fifo_if

// >>> design/cmd_fifo.sv
`timescale 1ns/1ps
module cmd_fifo
#(
	parameter int unsigned W = 9,
	parameter int unsigned DEPTH = 4
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// both sides of the buffer
	cmd_fifo_if.store f
);
	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [W-1:0] mem_q [DEPTH];
	logic [AW-1:0] wptr_q, wptr_d, rptr_q, rptr_d;
	logic [AW:0] count_q, count_d;
	logic push, pop;

	assign f.in_ready = (count_q != (AW+1)'(DEPTH));
	assign f.out_valid = (count_q != '0);
	assign f.out_data = mem_q[rptr_q];
	assign push = f.in_valid && f.in_ready;
	assign pop = f.out_valid && f.out_ready;

	always_comb
	begin
		wptr_d = wptr_q;
		rptr_d = rptr_q;
		count_d = count_q;
		if (push)
			wptr_d = (wptr_q == AW'(DEPTH-1)) ? '0 : wptr_q + 1'b1;
		if (pop)
			rptr_d = (rptr_q == AW'(DEPTH-1)) ? '0 : rptr_q + 1'b1;
		if (push && !pop)
			count_d = count_q + 1'b1;
		else if (pop && !push)
			count_d = count_q - 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wptr_q <= '0;
			rptr_q <= '0;
			count_q <= '0;
		end
		else
		begin
			wptr_q <= wptr_d;
			rptr_q <= rptr_d;
			count_q <= count_d;
		end
	end

	// storage needs no reset; count guards every read
	always_ff @(posedge clk)
	begin
		if (push)
			mem_q[wptr_q] <= f.in_data;
	end
endmodule : cmd_fifo

// >>> testbench/spi_port_checker.sv
`timescale 1ns/1ps
module spi_port_checker
#(
	parameter int unsigned PROC_MIN_CYC = 20,
	parameter int unsigned PROC_MAX_CYC = 200
)
(
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic RST_N,
	// pins
	input wire logic SERIAL_SEL,
	input wire logic GPIO_THREE_OUT,
	input wire logic PORT_SELECT_N,
	input wire logic SPI_SCK,
	input wire logic SPI_MISO,
	input wire logic SPI_MISO_OE,
	input wire logic GENERAL_PIN_THREE,
	// command stream
	input wire spi_cmd_pkg::cmd_byte_t CMD_DATA,
	input wire logic CMD_VALID,
	input wire logic CMD_READY
);
	import spi_cmd_pkg::*;
	logic [19:0] idle_q;
	logic [19:0] idle_d;
	// cycles since select rose, saturating
	always_comb
		idle_d = PORT_SELECT_N ? (&idle_q ? idle_q : idle_q + 20'h1) : 20'h0;
	always_ff @(posedge SYS_CLK)
		idle_q <= RST_N ? idle_d : 20'h0;
	//////////////////////////////
	default clocking @(posedge SYS_CLK);
	endclocking
	default disable iff (!RST_N);
	sequence sel_fall;
		SERIAL_SEL && $fell(PORT_SELECT_N);
	endsequence
	sequence sel_held;
		(SERIAL_SEL && !PORT_SELECT_N)[*5];
	endsequence
	// sync lag: clock must sit high a while before miso is judged
	sequence sck_steady;
		(!PORT_SELECT_N && SPI_SCK && SPI_MISO_OE)[*6];
	endsequence
	busy_rise_a:
		assert property (sel_fall |-> ##[3:4] GENERAL_PIN_THREE) else $error("busy late");
	oe_follow_a:
		assert property (sel_held |-> SPI_MISO_OE) else $error("oe missing");
	miso_release_a:
		assert property (PORT_SELECT_N[*5] |-> !SPI_MISO_OE) else $error("oe stuck");
	miso_quiet_a:
		assert property (!SPI_MISO_OE |-> !SPI_MISO) else $error("miso not quiet");
	miso_steady_a:
		assert property (sck_steady |-> $stable(SPI_MISO)) else $error("miso moved");
	cmd_hold_a:
		assert property (CMD_VALID && !CMD_READY |=> CMD_VALID && $stable(CMD_DATA)) else $error("cmd dropped");
	pin_gpio_a:
		assert property (!SERIAL_SEL |=> GENERAL_PIN_THREE == $past(GPIO_THREE_OUT)) else $error("pin three");
	busy_min_a:
		assert property ($fell(GENERAL_PIN_THREE) && SERIAL_SEL && $past(SERIAL_SEL) |-> idle_q >= PROC_MIN_CYC)
			else $error("busy short");
	busy_max_a:
		assert property (GENERAL_PIN_THREE && SERIAL_SEL && PORT_SELECT_N |-> idle_q <= PROC_MAX_CYC + 8)
			else $error("busy long");
endmodule : spi_port_checker

bind spi_command_port_busy spi_port_checker #(.PROC_MIN_CYC(PROC_MIN_CYC), .PROC_MAX_CYC(PROC_MAX_CYC))
	i_spi_port_checker (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .SERIAL_SEL(SERIAL_SEL),
	.GPIO_THREE_OUT(GPIO_THREE_OUT), .PORT_SELECT_N(PORT_SELECT_N), .SPI_SCK(SPI_SCK), .SPI_MISO(SPI_MISO),
	.SPI_MISO_OE(SPI_MISO_OE), .GENERAL_PIN_THREE(GENERAL_PIN_THREE), .CMD_DATA(CMD_DATA),
	.CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY));

// >>> testbench/spi_host.sv
`timescale 1ns/1ps
module spi_host
#(
	parameter int unsigned N = 16
)
(
	// link pins
	output logic sel_n,
	output logic sck,
	output logic mosi,
	input wire logic miso,
	input wire logic miso_oe,
	input wire logic busy
);
	logic last_q;
	// released line shows the opposite of its last level
	wire line_v = miso_oe ? miso : !last_q;
	initial
	begin
		sel_n = 1'b1;
		sck = 1'b1;
		mosi = 1'b0;
		last_q = 1'b0;
	end
	task automatic xfer(input logic [N-1:0] tx, input logic hold, output logic [N-1:0] rx);
		if (hold)
			wait (busy === 1'b0);
		// keeps link edges off the system clock edges
		#3;
		sel_n = 1'b0;
		#125;
		for (int i = N - 1; i >= 0; i--)
		begin
			sck = 1'b0;
			mosi = tx[i];
			#62.5;
			sck = 1'b1;
			rx[i] = line_v;
			last_q = line_v;
			#62.5;
		end
		sel_n = 1'b1;
		mosi = !mosi;
	endtask : xfer
endmodule : spi_host

// >>> testbench/tb.sv
`timescale 1ns/1ps
module tb;
	import spi_cmd_pkg::*;
	localparam int unsigned NB = 2;
	localparam int unsigned W = NB * 8;
	logic sys_clk, rst_n, serial_sel, gpio_three_out, result_valid, stall;
	logic cmd_ready = 1'b0;
	logic sel_n, sck, mosi, miso, miso_oe, pin_three, cmd_last, cmd_valid;
	logic [W-1:0] result_data, rx, stored;
	logic [31:0] rng;
	// own stream: stall draws share a time step with the main thread, one state would race
	logic [31:0] ready_rng = 32'hd3b5;
	cmd_byte_t cmd_data;
	logic [8:0] expq[$];
	int mismatches;
	int checks_done;
	spi_command_port_busy #(.DGRAM_BYTES(NB), .PROC_MIN_CYC(20), .PROC_MAX_CYC(200)) i_spi_command_port_busy (
		.SYS_CLK(sys_clk), .RST_N(rst_n), .SERIAL_SEL(serial_sel), .GPIO_THREE_OUT(gpio_three_out),
		.PORT_SELECT_N(sel_n), .SPI_SCK(sck), .SPI_MOSI(mosi), .SPI_MISO(miso), .SPI_MISO_OE(miso_oe),
		.GENERAL_PIN_THREE(pin_three), .CMD_DATA(cmd_data), .CMD_LAST(cmd_last), .CMD_VALID(cmd_valid),
		.CMD_READY(cmd_ready), .RESULT_DATA(result_data), .RESULT_VALID(result_valid));
	spi_host #(.N(W)) i_spi_host (.sel_n(sel_n), .sck(sck), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
		.busy(pin_three));
	//////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	function automatic logic [W-1:0] exp_reply(input logic [W-1:0] res, input logic given);
		return given ? res : '0;
	endfunction : exp_reply
	task automatic check(input logic [W-1:0] got, input logic [W-1:0] exp, input string what);
		checks_done++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : test_done
	task automatic give_result(input logic [W-1:0] res);
		@(posedge sys_clk);
		#1;
		result_data = res;
		result_valid = 1'b1;
		@(posedge sys_clk);
		#1;
		result_valid = 1'b0;
	endtask : give_result
	task automatic send(input logic [W-1:0] v, input logic hold);
		for (int b = NB - 1; b >= 0; b--)
			expq.push_back({b == 0, v[b*8 +: 8]});
		i_spi_host.xfer(v, hold, rx);
	endtask : send
	//////////////////////////////
	initial
	begin
		sys_clk = 1'b0;
		forever
			#5 sys_clk = ~sys_clk;
	end
	// random stalls on the command stream
	always @(posedge sys_clk)
	begin
		#1;
		ready_rng = xs(ready_rng);
		cmd_ready = !stall && ready_rng[2];
	end
	always @(posedge sys_clk)
		if (rst_n === 1'b1 && cmd_valid === 1'b1 && cmd_ready === 1'b1)
			check(W'({cmd_last, cmd_data}), W'(expq.pop_front()), "cmd byte");
	initial
	begin
		#400000;
		mismatches++;
		$display("mismatch at %0t: watchdog", $time);
		test_done();
	end
	initial
	begin
		rng = 32'd54197;
		{rst_n, serial_sel, gpio_three_out, result_valid} = '0;
		result_data = '0;
		stall = 1'b1;
		mismatches = 0;
		checks_done = 0;
		repeat (12) @(posedge sys_clk);
		#1;
		rst_n = 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			rng = xs(rng);
			gpio_three_out = rng[0];
			repeat (2) @(posedge sys_clk);
			#1;
			check(W'(pin_three), W'(gpio_three_out), "pin three");
		end
		$display("pin three test done");
		// low first, so the switch to busy shows no false fall
		gpio_three_out = 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
		serial_sel = 1'b1;
		stored = '0;
		for (int k = 0; k < 7; k++)
		begin
			// first two frames leave three bytes in the buffer and one in the output stage
			stall = (k < 2);
			rng = xs(rng);
			send(rng[W-1:0], 1'b1);
			check(rx, stored, "reply");
			rng = xs(rng);
			repeat (k == 3 ? 0 : rng[4:0]) @(posedge sys_clk);
			if (k != 4)
				give_result(rng[W+4:5]);
			// clash frame while busy; no result follows
			if (k == 3)
				send(~rng[W-1:0], 1'b0);
			stored = exp_reply(rng[W+4:5], k != 3 && k != 4);
			$display("frame %0d done", k);
		end
		stall = 1'b0;
		repeat (40) @(posedge sys_clk);
		check(W'(expq.size()), '0, "bytes left");
		test_done();
	end
endmodule : tb
